// *** kic_cfg.svh ***
// Constants of the keypad and indicator block: offsets, fields, resets, times.
// Assumes a 40 MHz system clock and 32-bit word-aligned bus registers.
`ifndef KIC_CFG_SVH
`define KIC_CFG_SVH
// ----------------------------------------------------------------------
// Register word indexes, byte address is four times the index
// ----------------------------------------------------------------------
`define KIC_OFS_CTRL 3'h0
`define KIC_OFS_VALUE 3'h1
`define KIC_OFS_MENU 3'h2
`define KIC_OFS_SETPT 3'h3
`define KIC_OFS_DISP 3'h4
`define KIC_OFS_STATUS 3'h5
// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define KIC_CTRL_MODE 1:0
`define KIC_CTRL_KPSET 2
`define KIC_CTRL_MONSP 3
`define KIC_CTRL_JOGFN 4
`define KIC_CTRL_PROT 6:5
`define KIC_CTRL_MODFL 8:7
`define KIC_CTRL_UNIT 11:9
`define KIC_CTRL_W 12
`define KIC_CTRL_RST 12'h000
`define KIC_STAT_REJ 0
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define KIC_CLK_MHZ 40
`define KIC_DEB_US 1000
`define KIC_DEB_CYC (`KIC_DEB_US * `KIC_CLK_MHZ)
`define KIC_QUICK_US 125000
`define KIC_QUICK_CYC (`KIC_QUICK_US * `KIC_CLK_MHZ)
`define KIC_SLOW_RATIO 2'h3
`define KIC_MON_LAST 3'h7
`endif

// *** kic_pkg.sv ***
// Types of the keypad and indicator block.
// Assumes kic_cfg.svh is included before use.
`include "kic_cfg.svh"
package kic_pkg;
  typedef enum logic [1:0] {
    KIC_MONITOR = 2'h0,
    KIC_GROUP = 2'h1,
    KIC_CODE = 2'h3,
    KIC_VALUE = 2'h2
  } kic_mode_t;
  typedef enum logic [1:0] {
    KIC_SRC_KEYPAD = 2'h0,
    KIC_SRC_TERMINAL = 2'h1,
    KIC_SRC_SERIAL = 2'h2
  } kic_src_t;
  typedef struct packed {
    logic running;
    logic zero_freq;
    logic reverse;
    logic ramping;
    logic stopping;
    logic fault;
    kic_src_t src;
  } kic_drv_status_t;
  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] deb;
    logic [5:0][23:0] cnt;
    logic [23:0] blink_cnt;
    logic quick;
    logic [1:0] slow_div;
    logic slow;
    logic [11:0] ctrl;
    logic [15:0] value;
    logic [3:0] grp;
    logic [7:0] code;
    logic [15:0] setpt;
    logic [15:0] disp;
    logic [1:0] dsel;
    logic [2:0] mon_idx;
    logic rev_dir;
    logic rej;
    logic wr_pend;
    logic [2:0] wr_idx;
    logic [31:0] hrdata;
    logic hready;
    logic [27:0] seg;
    logic [2:0] unit;
    logic [4:0] led;
    logic cmd_run;
    logic cmd_stop;
    logic cmd_jog;
    logic cmd_clr;
  } kic_state_t;
endpackage : kic_pkg

// *** kic_keypad.sv ***
// Keypad, encoder, display and status indicator logic of the drive panel.
// Assumes an AHB-Lite master and a drive core on the same clock.
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "kic_cfg.svh"
module kic_keypad #(
  parameter int DEB_CYC = `KIC_DEB_CYC,
  parameter int QUICK_CYC = `KIC_QUICK_CYC
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RESET,
  // AHB-Lite slave.
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Panel keys and encoder pins.
  input wire logic KEY_SHIFT,
  input wire logic KEY_JOG,
  input wire logic KEY_RUN,
  input wire logic KEY_STOP,
  input wire logic ENC_A,
  input wire logic ENC_B,
  // Drive core status.
  input wire kic_pkg::kic_drv_status_t DRV_STATUS,
  // Drive core commands.
  output logic CMD_RUN,
  output logic CMD_STOP,
  output logic CMD_JOG,
  output logic CMD_FAULT_CLEAR,
  output logic CMD_DIR_REVERSE,
  // Display and lamps.
  output logic [27:0] SEGMENTS,
  output logic [2:0] UNIT_LEDS,
  output logic RUN_INDICATOR,
  output logic FORWARD_DIRECTION_INDICATOR,
  output logic REVERSE_DIRECTION_INDICATOR,
  output logic FAULT_INDICATOR,
  output logic REMOTE_INDICATOR
);

  // ----------------------------------------------------------------------
  // Hex digit to segments, bit 0 is segment a.
  // ----------------------------------------------------------------------
  function automatic logic [6:0] hex2seg(input logic [3:0] h);
    case (h)
      4'h0: hex2seg = 7'h3F;
      4'h1: hex2seg = 7'h06;
      4'h2: hex2seg = 7'h5B;
      4'h3: hex2seg = 7'h4F;
      4'h4: hex2seg = 7'h66;
      4'h5: hex2seg = 7'h6D;
      4'h6: hex2seg = 7'h7D;
      4'h7: hex2seg = 7'h07;
      4'h8: hex2seg = 7'h7F;
      4'h9: hex2seg = 7'h6F;
      4'hA: hex2seg = 7'h77;
      4'hB: hex2seg = 7'h7C;
      4'hC: hex2seg = 7'h39;
      4'hD: hex2seg = 7'h5E;
      4'hE: hex2seg = 7'h79;
      default: hex2seg = 7'h71;
    endcase
  endfunction : hex2seg

  kic_pkg::kic_state_t q;
  kic_pkg::kic_state_t n;

  // ----------------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [5:0] pins;
    logic [5:0] press;
    logic step;
    logic cw;
    logic editable;
    logic blank;
    logic [15:0] shown;
    logic [15:0] inc;
    logic [1:0] mfl;
    logic keypad;
    logic fwd_act;
    logic rev_act;
    logic [2:0] idx;
    logic rej_set;
    pins = {ENC_B, ENC_A, KEY_STOP, KEY_RUN, KEY_JOG, KEY_SHIFT};
    n = q;
    press = 6'h00;
    step = 1'b0;
    cw = 1'b0;
    editable = 1'b0;
    blank = 1'b0;
    shown = 16'h0000;
    inc = 16'h0000;
    mfl = 2'h0;
    keypad = 1'b0;
    fwd_act = 1'b0;
    rev_act = 1'b0;
    idx = 3'h0;
    rej_set = 1'b0;
    // Two-stage synchronisers and debounce counters.
    n.sync1 = pins;
    n.sync2 = q.sync1;
    for (int i = 0; i < 6; i++)
    begin
      if (q.sync2[i] == q.deb[i])
      begin
        n.cnt[i] = 24'h000000;
      end
      else if (q.cnt[i] >= 24'(DEB_CYC - 1))
      begin
        n.cnt[i] = 24'h000000;
        n.deb[i] = q.sync2[i];
        press[i] = q.sync2[i];
      end
      else
      begin
        n.cnt[i] = q.cnt[i] + 24'h000001;
      end
    end
    // Quick and slow flicker phases.
    if (q.blink_cnt >= 24'(QUICK_CYC - 1))
    begin
      n.blink_cnt = 24'h000000;
      n.quick = ~q.quick;
      if (q.quick)
      begin
        n.slow_div = q.slow_div + 2'h1;
        if (q.slow_div == `KIC_SLOW_RATIO)
        begin
          n.slow = ~q.slow;
        end
      end
    end
    else
    begin
      n.blink_cnt = q.blink_cnt + 24'h000001;
    end
    // Edit permission.
    mfl = q.ctrl[`KIC_CTRL_MODFL];
    editable = (q.ctrl[`KIC_CTRL_PROT] == 2'h0)
      && !mfl[1]
      && !(mfl == 2'h1 && DRV_STATUS.running);
    // Encoder: one step per debounced rising edge of channel A.
    step = press[4];
    cw = ~q.deb[5];
    inc = 16'h0001 << {q.dsel, 2'h0};
    keypad = (DRV_STATUS.src == kic_pkg::KIC_SRC_KEYPAD);
    n.cmd_run = 1'b0;
    n.cmd_stop = 1'b0;
    n.cmd_jog = 1'b0;
    n.cmd_clr = 1'b0;
    case (kic_pkg::kic_mode_t'(q.ctrl[`KIC_CTRL_MODE]))
      kic_pkg::KIC_MONITOR:
      begin
        if (step && (q.ctrl[`KIC_CTRL_KPSET] || q.ctrl[`KIC_CTRL_MONSP]))
        begin
          n.setpt = cw ? q.setpt + 16'h0001
            : q.setpt - 16'h0001;
        end
        if (press[0])
        begin
          n.mon_idx = (q.mon_idx == `KIC_MON_LAST) ? 3'h0
            : q.mon_idx + 3'h1;
        end
      end
      kic_pkg::KIC_GROUP:
      begin
        if (step)
        begin
          n.grp = cw ? q.grp + 4'h1
            : q.grp - 4'h1;
        end
      end
      kic_pkg::KIC_CODE:
      begin
        if (step)
        begin
          n.code = cw ? q.code + 8'h01
            : q.code - 8'h01;
        end
      end
      kic_pkg::KIC_VALUE:
      begin
        if (step && editable)
        begin
          n.value = cw ? q.value + inc
            : q.value - inc;
        end
        if (step && !editable)
        begin
          rej_set = 1'b1;
          n.rej = 1'b1;
        end
        if (press[0])
        begin
          n.dsel = q.dsel + 2'h1;
        end
      end
      default:
      begin
        n.grp = q.grp;
      end
    endcase
    // Keys towards the drive core.
    if (press[1])
    begin
      if (q.ctrl[`KIC_CTRL_JOGFN])
      begin
        n.rev_dir = ~q.rev_dir;
      end
      else if (keypad)
      begin
        n.cmd_jog = 1'b1;
      end
    end
    n.cmd_run = press[2] && keypad;
    n.cmd_stop = press[3] && keypad;
    n.cmd_clr = press[3] && DRV_STATUS.fault;
    // Bus data phase write, applied before the read below.
    if (q.wr_pend)
    begin
      case (q.wr_idx)
        `KIC_OFS_CTRL: n.ctrl = HWDATA[`KIC_CTRL_W-1:0];
        `KIC_OFS_VALUE: n.value = HWDATA[15:0];
        `KIC_OFS_MENU: {n.code, n.grp} = HWDATA[11:0];
        `KIC_OFS_SETPT: n.setpt = HWDATA[15:0];
        `KIC_OFS_DISP: n.disp = HWDATA[15:0];
        `KIC_OFS_STATUS:
        begin
          if (HWDATA[`KIC_STAT_REJ] && !n.rej)
          begin
            n.rej = 1'b0;
          end
          else if (HWDATA[`KIC_STAT_REJ] && !rej_set)
          begin
            n.rej = 1'b0;
          end
        end
        default: n.disp = n.disp;
      endcase
    end
    // Bus address phase.
    n.hready = 1'b1;
    n.wr_pend = 1'b0;
    n.hrdata = 32'h00000000;
    if (HSEL && HTRANS[1] && HREADY)
    begin
      idx = HADDR[4:2];
      n.wr_pend = HWRITE && (HADDR[31:5] == 27'h0000000);
      n.wr_idx = idx;
      if (!HWRITE && HADDR[31:5] == 27'h0000000)
      begin
        case (idx)
          `KIC_OFS_CTRL: n.hrdata = {20'h00000, n.ctrl};
          `KIC_OFS_VALUE: n.hrdata = {16'h0000, n.value};
          `KIC_OFS_MENU: n.hrdata = {20'h00000, n.code, n.grp};
          `KIC_OFS_SETPT: n.hrdata = {16'h0000, n.setpt};
          `KIC_OFS_DISP: n.hrdata = {16'h0000, n.disp};
          `KIC_OFS_STATUS:
            n.hrdata = {24'h000000, editable, n.rev_dir, n.mon_idx,
              n.dsel, n.rej};
          default: n.hrdata = 32'h00000000;
        endcase
      end
    end
    // Display content and digit blink.
    case (kic_pkg::kic_mode_t'(n.ctrl[`KIC_CTRL_MODE]))
      kic_pkg::KIC_MONITOR:
        shown = n.ctrl[`KIC_CTRL_MONSP] ? n.setpt : n.disp;
      kic_pkg::KIC_GROUP: shown = {12'h000, n.grp};
      kic_pkg::KIC_CODE: shown = {n.grp, 4'h0, n.code};
      default: shown = n.value;
    endcase
    for (int d = 0; d < 4; d++)
    begin
      blank = (kic_pkg::kic_mode_t'(n.ctrl[`KIC_CTRL_MODE])
        == kic_pkg::KIC_VALUE) && editable
        && (n.dsel == 2'(d)) && !q.slow;
      n.seg[d*7 +: 7] = blank ? 7'h00 : hex2seg(shown[d*4 +: 4]);
    end
    n.unit = n.ctrl[`KIC_CTRL_UNIT];
    // Status lamps: run, forward, reverse, fault, remote.
    fwd_act = !DRV_STATUS.reverse;
    rev_act = DRV_STATUS.reverse;
    n.led[0] = DRV_STATUS.running
      && (DRV_STATUS.zero_freq ? q.quick : 1'b1);
    n.led[1] = DRV_STATUS.stopping ? (fwd_act && q.slow)
      : DRV_STATUS.running && fwd_act
        && (DRV_STATUS.ramping ? q.quick : 1'b1);
    n.led[2] = DRV_STATUS.stopping ? (rev_act && q.slow)
      : DRV_STATUS.running && rev_act
        && (DRV_STATUS.ramping ? q.quick : 1'b1);
    n.led[3] = DRV_STATUS.fault && q.quick;
    case (DRV_STATUS.src)
      kic_pkg::KIC_SRC_KEYPAD: n.led[4] = 1'b0;
      kic_pkg::KIC_SRC_TERMINAL: n.led[4] = 1'b1;
      default: n.led[4] = q.quick;
    endcase
  end

  // ----------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      q <= '0;
      q.ctrl <= `KIC_CTRL_RST;
      q.hready <= 1'b1;
    end
    else
    begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------
  assign HRDATA = q.hrdata;
  assign HREADYOUT = q.hready;
  assign HRESP = 1'b0;
  assign CMD_RUN = q.cmd_run;
  assign CMD_STOP = q.cmd_stop;
  assign CMD_JOG = q.cmd_jog;
  assign CMD_FAULT_CLEAR = q.cmd_clr;
  assign CMD_DIR_REVERSE = q.rev_dir;
  assign SEGMENTS = q.seg;
  assign UNIT_LEDS = q.unit;
  assign RUN_INDICATOR = q.led[0];
  assign FORWARD_DIRECTION_INDICATOR = q.led[1];
  assign REVERSE_DIRECTION_INDICATOR = q.led[2];
  assign FAULT_INDICATOR = q.led[3];
  assign REMOTE_INDICATOR = q.led[4];

endmodule : kic_keypad
`default_nettype wire

// *** kic_keypad_sva.sv ***
// Assertions on the ports of the keypad and indicator block.
// Assumes one clock and the flicker time base set by QUICK_CYC.
`timescale 1ns/1ps
`default_nettype none
module kic_keypad_sva #(
  parameter int QUICK_CYC = 8
) (
  // Clock, reset and bus.
  input wire logic CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HRESP,
  // Drive core side.
  input wire kic_pkg::kic_drv_status_t DRV_STATUS,
  input wire logic CMD_RUN,
  input wire logic CMD_JOG,
  // Lamps.
  input wire logic RUN_INDICATOR,
  input wire logic FORWARD_DIRECTION_INDICATOR,
  input wire logic FAULT_INDICATOR,
  input wire logic REMOTE_INDICATOR
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  localparam int QW = QUICK_CYC + 1;
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (RESET);
  a_read_stand: assert property (!(HSEL && HTRANS[1] && !HWRITE && HREADY)
    |=> HRDATA == 32'h0) else $error("Read data held too long.");
  a_resp_okay: assert property (HRESP == 1'b0) else $error("Bad response.");
  a_run_pulse: assert property (CMD_RUN |=> !CMD_RUN)
    else $error("Run command longer than one cycle.");
  a_run_source: assert property (CMD_RUN
    |-> $past(DRV_STATUS.src) == 2'h0)
    else $error("Run command without keypad control.");
  a_jog_source: assert property (CMD_JOG
    |-> $past(DRV_STATUS.src) == 2'h0)
    else $error("Jog command without keypad control.");
  a_remote_key: assert property ((DRV_STATUS.src == 2'h0)[*3]
    |-> !REMOTE_INDICATOR) else $error("Source lamp lit for keypad.");
  a_remote_term: assert property ((DRV_STATUS.src == 2'h1)[*3]
    |-> REMOTE_INDICATOR) else $error("Source lamp dark for terminal.");
  a_run_off: assert property ((!DRV_STATUS.running)[*3]
    |-> !RUN_INDICATOR) else $error("Run lamp lit while stopped.");
  a_run_zero: assert property ((DRV_STATUS.running &&
    DRV_STATUS.zero_freq)[*3] |-> ##[0:QW] $changed(RUN_INDICATOR))
    else $error("Run lamp not flickering at zero frequency.");
  a_fault_flick: assert property (DRV_STATUS.fault[*3]
    |-> ##[0:QW] $changed(FAULT_INDICATOR))
    else $error("Fault lamp not flickering.");
  a_quick_period: assert property ((DRV_STATUS.ramping &&
    !DRV_STATUS.stopping)[*3] ##0 $changed(FORWARD_DIRECTION_INDICATOR)
    |=> ($stable(FORWARD_DIRECTION_INDICATOR) || !DRV_STATUS.ramping)[*7])
    else $error("Quick flicker period wrong.");
  a_slow_period: assert property (DRV_STATUS.stopping[*3]
    ##0 $changed(FORWARD_DIRECTION_INDICATOR)
    |=> ($stable(FORWARD_DIRECTION_INDICATOR) || !DRV_STATUS.stopping)[*8])
    else $error("Slow flicker too fast.");
endmodule : kic_keypad_sva
bind kic_keypad kic_keypad_sva #(.QUICK_CYC(QUICK_CYC)) i_kic_keypad_sva (
  .CLK(CLK), .RESET(RESET), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HRDATA(HRDATA), .HRESP(HRESP), .DRV_STATUS(DRV_STATUS),
  .CMD_RUN(CMD_RUN), .CMD_JOG(CMD_JOG), .RUN_INDICATOR(RUN_INDICATOR),
  .FORWARD_DIRECTION_INDICATOR(FORWARD_DIRECTION_INDICATOR),
  .FAULT_INDICATOR(FAULT_INDICATOR), .REMOTE_INDICATOR(REMOTE_INDICATOR));
`default_nettype wire

// *** kic_operator.sv ***
// Operator model: presses panel keys and turns the encoder knob.
// Assumes the block debounce settles well inside twelve clock cycles.
`timescale 1ns/1ps
`default_nettype none
module kic_operator (
  // Clock.
  input wire logic clk,
  // Keys and encoder.
  output logic [3:0] keys,
  output logic enc_a,
  output logic enc_b
);
  initial
  begin
    keys = 4'h0;
    enc_a = 1'b0;
    enc_b = 1'b0;
  end
  // Codes 0 to 3 press a key, 4 turns clockwise, 5 counterclockwise.
  task automatic press(input int k);
    @(posedge clk);
    if (k > 3)
      enc_b <= (k == 5);
    repeat (8) @(posedge clk);
    if (k > 3)
      enc_a <= 1'b1;
    else
      keys[k] <= 1'b1;
    repeat (12) @(posedge clk);
    keys <= 4'h0;
    enc_a <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : press
endmodule : kic_operator
`default_nettype wire

// *** kic_keypad_test.sv ***
// Testbench of the keypad and indicator block.
// Assumes the design, its package, checker and operator model compiled first.
`timescale 1ns/1ps
`default_nettype none
module kic_keypad_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, v, w;
  logic hreadyout, enc_a, enc_b, run_l, fwd_l, rev_l, flt_l, rem_l;
  logic [3:0] keys;
  logic cmd_run, cmd_stop, cmd_jog, cmd_clr, dir_rev;
  logic [27:0] seg;
  logic [2:0] unit;
  logic [5:0] t;
  logic [4:0] s5;
  logic [9:0] cls;
  logic [9:0] lcls [8] = '{10'h140, 10'h1C0, 10'h180, 10'h00C, 10'h340,
    10'h001, 10'h003, 10'h110};
  int fl [5];
  wire [4:0] lmp = {run_l, fwd_l, rev_l, flt_l, rem_l};
  logic [5:0] tbl [8] = '{6'h01, 6'h10, 6'h20, 6'h08, 6'h0C, 6'h06, 6'h05,
    6'h03};
  logic [7:0] lamp_tbl [8] = '{8'h80, 8'h90, 8'h88, 8'h04, 8'hC0, 8'h01,
    8'h02, 8'hA0};
  kic_pkg::kic_drv_status_t drv = '0;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int n_run = 0, n_stop = 0, n_jog = 0, n_clr = 0, n;
  always #12.5 clk = ~clk;
  kic_operator i_kic_operator (.clk(clk), .keys(keys), .enc_a(enc_a),
    .enc_b(enc_b));
  kic_keypad #(.DEB_CYC(4), .QUICK_CYC(8)) i_kic_keypad (.CLK(clk),
    .RESET(reset), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(), .KEY_SHIFT(keys[0]),
    .KEY_JOG(keys[1]), .KEY_RUN(keys[2]), .KEY_STOP(keys[3]), .ENC_A(enc_a),
    .ENC_B(enc_b), .DRV_STATUS(drv), .CMD_RUN(cmd_run), .CMD_STOP(cmd_stop),
    .CMD_JOG(cmd_jog), .CMD_FAULT_CLEAR(cmd_clr), .CMD_DIR_REVERSE(dir_rev),
    .SEGMENTS(seg), .UNIT_LEDS(unit), .RUN_INDICATOR(run_l),
    .FORWARD_DIRECTION_INDICATOR(fwd_l), .REVERSE_DIRECTION_INDICATOR(rev_l),
    .FAULT_INDICATOR(flt_l), .REMOTE_INDICATOR(rem_l));
  always @(posedge clk)
  begin
    n_run += int'(cmd_run === 1'b1);
    n_stop += int'(cmd_stop === 1'b1);
    n_jog += int'(cmd_jog === 1'b1);
    n_clr += int'(cmd_clr === 1'b1);
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [31:0] a,
    input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do
      @(posedge clk);
    while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do
      @(posedge clk);
    while (hreadyout !== 1'b1);
    v = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [31:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic p(input int k);
    i_kic_operator.press(k);
  endtask : p
  task automatic blinks();
    logic [27:0] s;
    n = 0;
    s = seg;
    repeat (140)
    begin
      @(negedge clk);
      n += int'(seg !== s);
      s = seg;
    end
  endtask : blinks
  task automatic finish_test();
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    @(negedge clk);
    check(32'(seg), 32'({4{7'h3F}}));
    rd(32'h0);
    check(v, 32'h0);
    wr(32'h20, 32'hFFF);
    rd(32'h0);
    check(v, 32'h0);
    rd(32'h18);
    check(v, 32'h0);
    for (int u = 0; u < 8; u++)
    begin
      wr(32'h0, 32'(u) << 9);
      @(negedge clk);
      @(negedge clk);
      check(32'(unit), 32'(u));
    end
    wr(32'h0, 32'h0);
    p(2);
    drv <= 8'h04;
    p(3);
    drv <= 8'h00;
    p(1);
    check(32'(n_run), 32'h1);
    check(32'(n_stop), 32'h1);
    check(32'(n_clr), 32'h1);
    check(32'(n_jog), 32'h1);
    drv <= 8'h01;
    p(2);
    p(3);
    p(1);
    check(32'(n_run + n_stop + n_jog), 32'h3);
    drv <= 8'h00;
    wr(32'h0, 32'h10);
    w = 32'(dir_rev);
    p(1);
    check(32'(dir_rev), 32'(!w[0]));
    check(32'(n_jog), 32'h1);
    wr(32'h0, 32'h1);
    wr(32'h8, 32'h105);
    p(4);
    rd(32'h8);
    check(v, 32'h106);
    p(5);
    p(5);
    rd(32'h8);
    check(v, 32'h104);
    wr(32'h0, 32'h3);
    p(4);
    rd(32'h8);
    check(v, 32'h114);
    p(5);
    rd(32'h8);
    check(v, 32'h104);
    wr(32'h0, 32'hC);
    wr(32'hC, 32'h100);
    p(5);
    rd(32'hC);
    check(v, 32'hFF);
    check(32'(seg), 32'({7'h3F, 7'h3F, 7'h71, 7'h71}));
    rd(32'h14);
    w = v;
    p(0);
    rd(32'h14);
    check(32'(3'(v[5:3] - w[5:3])), 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      t = tbl[i];
      drv <= {t[1], 7'h00};
      wr(32'h0, {23'h0, t[3:2], t[5:4], 5'h02});
      wr(32'h14, 32'h1);
      wr(32'h4, 32'h1234);
      rd(32'h14);
      check(32'(v[7]), 32'(t[0]));
      blinks();
      check(32'(n != 0), 32'(t[0]));
      p(5);
      rd(32'h4);
      check(32'(v !== 32'h1234), 32'(t[0]));
      rd(32'h14);
      check(32'(v[0]), 32'(!t[0]));
      if (t[0])
      begin
        p(4);
        rd(32'h4);
        check(v, 32'h1234);
      end
    end
    w = v;
    rd(32'h14);
    w = v;
    p(0);
    rd(32'h14);
    check(32'(2'(v[2:1] - w[2:1])), 32'h1);
    foreach (lamp_tbl[i])
    begin
      @(posedge clk);
      drv <= lamp_tbl[i];
      repeat (4) @(negedge clk);
      s5 = lmp;
      fl = '{0, 0, 0, 0, 0};
      repeat (150)
      begin
        @(negedge clk);
        for (int b = 0; b < 5; b++)
          fl[b] += int'(lmp[b] !== s5[b]);
        s5 = lmp;
      end
      for (int b = 0; b < 5; b++)
        cls[2*b +: 2] = (fl[b] > 8) ? 2'h3
          : (fl[b] > 0) ? 2'h2 : {1'b0, s5[b]};
      check(32'(cls), 32'(lcls[i]));
    end
    @(negedge clk);
    check(32'({run_l, fwd_l, rev_l, flt_l, rem_l}), 32'h14);
    finish_test();
  end
endmodule : kic_keypad_test
`default_nettype wire
